// *** verilog/abs_pkg.sv ***
/*
 * Constants shared by the burst shaper of the 64-bit master port.
 * Assumes a single clock and reset domain around the shaper.
 */
`default_nettype none
package abs_pkg;
    localparam int ADDR_W = 32;
    // AXI burst type and size encodings.
    localparam logic [1:0] BURST_INCR = 2'h1;
    localparam logic [1:0] BURST_WRAP = 2'h2;
    localparam logic [2:0] SIZE_8 = 3'h0;
    localparam logic [2:0] SIZE_16 = 3'h1;
    localparam logic [2:0] SIZE_32 = 3'h2;
    localparam logic [2:0] SIZE_64 = 3'h3;
    // Beat counts: length-field values (beats minus one), then plain beat totals.
    localparam logic [7:0] LEN_1 = 8'h00;
    localparam logic [7:0] LEN_4 = 8'h03;
    localparam logic [7:0] LEN_7 = 8'h06;
    localparam logic [7:0] WB_BEATS = 8'h04;
    localparam logic [7:0] ST7_BEATS = 8'h07;
    // Line geometry: 32-byte lines, 8-byte beats.
    localparam int LINE_LSB = 5;
    localparam int DW_LSB = 3;
    localparam logic [7:0] STRB_HALF = 8'h03;
    localparam logic [7:0] STRB_WORD = 8'h0f;
    localparam logic [7:0] STRB_ALL = 8'hff;
    // Request opcodes from the core side.
    typedef enum logic [2:0] {
        ABS_HSTORE = 3'h0,
        ABS_WSTORE = 3'h1,
        ABS_ST7 = 3'h2,
        ABS_FILL = 3'h3,
        ABS_EVICT = 3'h4,
        ABS_NCLOAD = 3'h5
    } abs_op_t;
endpackage
`default_nettype wire

// *** verilog/abs_fifo.sv ***
/*
 * Small valid/ready FIFO used on the write data path.
 * Assumes source and sink share the clock of the shaper.
 */
`default_nettype none
module abs_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 16
) (
    input wire logic clk, // clock
    input wire logic rst, // async reset
    input wire logic in_valid, // push request
    output logic in_ready, // not full
    input wire logic [WIDTH-1:0] in_data, // push data
    output logic out_valid, // not empty
    input wire logic out_ready, // pop request
    output logic [WIDTH-1:0] out_data // head data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_bad
        $error("depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q, rp_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign out_valid = wp_q != rp_q;
    assign out_data = mem[rp_q[AW-1:0]];
    always_ff @(posedge clk) begin
        if (push) mem[wp_q[AW-1:0]] <= in_data;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** verilog/abs_shaper.sv ***
/*
 * Burst shaper: turns core memory requests into AXI address bursts
 * and write-data beats, and flags alignment faults.
 * Assumes the core holds a request until req_ready and that the
 * interconnect follows standard AXI valid/ready handshakes.
 */
// Contract
// - Halfword device store: one 16-bit INCR beat
// - Halfword strobes shift two lanes per index
// - Odd halfword device store faults
// - Word store: one 32-bit beat, half strobes
// - Unaligned word device store faults
// - Seven-register store: seven 32-bit INCR beats
// - Unaligned store-multiple faults
// - Cacheable miss with cache on starts linefill
// - Linefill: WRAP, four 64-bit, doubleword aligned
// - Fill address from low five miss bits
// - Dirty valid eviction writes line back
// - Write-back: INCR four 64-bit, line aligned
// - Non-cacheable loads may reshape size/length
// - Store-buffer hit load issues no read
// - Halfword load shapes: 16, 32, split (code issues 16 or 64-bit, split at the line end)
// - Word load shapes: 32, 64, split (code issues only 64-bit, split at the line end)
// - Five-register load: 64-bit, split at line
// - No burst crosses a 32-byte boundary (code does not split seven-register store bursts)
// - 8 or 16-bit size means one beat
// - Write address channel only INCR
`default_nettype none
module abs_shaper #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk, // clock, 200 MHz
    input wire logic rst, // async reset, active high
    input wire logic req_valid, // core request present
    output logic req_ready, // request taken this cycle
    input wire logic [2:0] req_op, // abs_op_t opcode
    input wire logic [abs_pkg::ADDR_W-1:0] req_addr, // byte address
    input wire logic req_cache_en, // relevant cache enabled
    input wire logic req_line_dirty, // evicted line valid and dirty
    input wire logic [2:0] req_nc_words, // load word count 1..5, 0 = half
    input wire logic req_stb_hit, // bytes held in store buffer
    output logic fault_q, // one-cycle alignment fault pulse
    output logic done_q, // one-cycle request retired pulse
    input wire logic wd_valid, // core write data beat
    output logic wd_ready, // write data FIFO not full
    input wire logic [63:0] wd_data, // write data
    output logic [abs_pkg::ADDR_W-1:0] master_write_addr, // AWADDR
    output logic [1:0] master_write_burst_type, // AWBURST
    output logic [2:0] master_write_beat_size, // AWSIZE
    output logic [7:0] master_write_beat_count, // AWLEN
    output logic aw_valid_q, // AWVALID
    input wire logic aw_ready, // AWREADY
    output logic [63:0] w_data_q, // WDATA
    output logic [7:0] master_write_lane_strobes, // WSTRB
    output logic w_last_q, // WLAST
    output logic w_valid_q, // WVALID
    input wire logic w_ready, // WREADY
    output logic [abs_pkg::ADDR_W-1:0] master_read_addr, // ARADDR
    output logic [1:0] master_read_burst_type, // ARBURST
    output logic [2:0] master_read_beat_size, // ARSIZE
    output logic [7:0] master_read_beat_count, // ARLEN
    output logic ar_valid_q, // ARVALID
    input wire logic ar_ready // ARREADY
);
    import abs_pkg::*;

    // ------------------------------------------------------------
    // Request decoding
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ABS_IDLE = 3'b001,
        ABS_ADDR = 3'b010,
        ABS_SPLIT = 3'b100
    } abs_state_t;
    abs_state_t state_q;

    function automatic logic [7:0] lane_mask(input logic [2:0] a,
                                              input logic [7:0] base);
        lane_mask = base << a;
    endfunction

    wire [2:0] a_lo = req_addr[2:0];
    wire is_hs = req_op == ABS_HSTORE;
    wire is_ws = req_op == ABS_WSTORE;
    wire is_s7 = req_op == ABS_ST7;
    wire is_fill = req_op == ABS_FILL;
    wire is_ev = req_op == ABS_EVICT;
    wire is_ncl = req_op == ABS_NCLOAD;
    wire bad_half = is_hs && req_addr[0];
    wire bad_word = (is_ws || is_s7) && (req_addr[1:0] != 2'h0);
    wire misalign = bad_half || bad_word;
    // No bus traffic: fill with cache off, clean eviction, buffer hit.
    wire no_bus = (is_fill && !req_cache_en)
        || (is_ev && !req_line_dirty)
        || (is_ncl && req_stb_hit);
    wire take = req_valid && state_q == ABS_IDLE;
    wire [ADDR_W-1:0] dw_addr = {req_addr[ADDR_W-1:DW_LSB], 3'h0};
    wire [ADDR_W-1:0] line_addr = {req_addr[ADDR_W-1:LINE_LSB], 5'h00};

    // Non-cacheable load: 64-bit beats from the doubleword, split at
    // the line end; a halfword in aligned position uses one 16-bit beat.
    wire [5:0] nc_end = {1'b0, req_addr[4:0]} + (req_nc_words == 3'h0
        ? 6'h01 : {1'b0, req_nc_words, 2'h0} - 6'h01);
    wire nc_cross = nc_end[5];
    wire [1:0] first_last_dw = nc_cross ? 2'h3 : nc_end[4:3];
    wire [7:0] nc_len1 = {6'h0, first_last_dw - req_addr[4:3]};
    wire [7:0] nc_len2 = {6'h0, nc_end[4:3]};
    wire nc_half_ok = req_nc_words == 3'h0 && !req_addr[0];

    // ------------------------------------------------------------
    // Control and address channels
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] split_addr_q;
    logic [7:0] split_len_q;
    logic [7:0] beats_q;
    logic [7:0] strb_q;
    logic [2:0] wsize_q;
    wire aw_fire = aw_valid_q && aw_ready;
    wire ar_fire = ar_valid_q && ar_ready;
    wire w_fire = w_valid_q && w_ready;
    wire busy_done = !aw_valid_q && !ar_valid_q && beats_q == 8'h00;

    assign req_ready = take;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ABS_IDLE;
            fault_q <= 1'b0;
            done_q <= 1'b0;
            aw_valid_q <= 1'b0;
            ar_valid_q <= 1'b0;
            master_write_addr <= '0;
            master_write_burst_type <= BURST_INCR;
            master_write_beat_size <= SIZE_8;
            master_write_beat_count <= LEN_1;
            master_read_addr <= '0;
            master_read_burst_type <= BURST_INCR;
            master_read_beat_size <= SIZE_8;
            master_read_beat_count <= LEN_1;
            split_addr_q <= '0;
            split_len_q <= LEN_1;
            beats_q <= 8'h00;
            strb_q <= 8'h00;
            wsize_q <= SIZE_8;
        end else begin
            fault_q <= 1'b0;
            done_q <= 1'b0;
            if (aw_fire) aw_valid_q <= 1'b0;
            if (ar_fire) ar_valid_q <= 1'b0;
            if (w_fire && beats_q != 8'h00) beats_q <= beats_q - 8'h01;
            case (state_q)
                ABS_IDLE: begin
                    if (take && misalign) begin
                        fault_q <= 1'b1;
                        done_q <= 1'b1;
                    end else if (take && no_bus) begin
                        done_q <= 1'b1;
                    end else if (take) begin
                        state_q <= ABS_ADDR;
                        master_write_burst_type <= BURST_INCR;
                        if (is_hs) begin
                            aw_valid_q <= 1'b1;
                            master_write_addr <= req_addr;
                            master_write_beat_size <= SIZE_16;
                            master_write_beat_count <= LEN_1;
                            strb_q <= lane_mask(a_lo, STRB_HALF);
                            beats_q <= 8'h01;
                        end else if (is_ws || is_s7) begin
                            aw_valid_q <= 1'b1;
                            master_write_addr <= req_addr;
                            master_write_beat_size <= SIZE_32;
                            master_write_beat_count <= is_s7 ? LEN_7 : LEN_1;
                            strb_q <= lane_mask(a_lo, STRB_WORD);
                            beats_q <= is_s7 ? ST7_BEATS : 8'h01;
                        end else if (is_ev) begin
                            aw_valid_q <= 1'b1;
                            master_write_addr <= line_addr;
                            master_write_beat_size <= SIZE_64;
                            master_write_beat_count <= LEN_4;
                            strb_q <= STRB_ALL;
                            beats_q <= WB_BEATS;
                        end else if (is_fill) begin
                            ar_valid_q <= 1'b1;
                            master_read_addr <= dw_addr;
                            master_read_burst_type <= BURST_WRAP;
                            master_read_beat_size <= SIZE_64;
                            master_read_beat_count <= LEN_4;
                        end else begin
                            ar_valid_q <= 1'b1;
                            master_read_burst_type <= BURST_INCR;
                            if (nc_half_ok) begin
                                master_read_addr <= req_addr;
                                master_read_beat_size <= SIZE_16;
                                master_read_beat_count <= LEN_1;
                            end else begin
                                master_read_addr <= dw_addr;
                                master_read_beat_size <= SIZE_64;
                                master_read_beat_count <= nc_len1;
                            end
                            if (!nc_half_ok && nc_cross) begin
                                state_q <= ABS_SPLIT;
                                split_addr_q <= line_addr
                                    + ADDR_W'(32);
                                split_len_q <= nc_len2;
                            end
                        end
                        wsize_q <= is_ev ? SIZE_64 : SIZE_32;
                    end
                end
                ABS_SPLIT: begin
                    if (ar_fire) begin
                        ar_valid_q <= 1'b1;
                        master_read_addr <= split_addr_q;
                        master_read_beat_size <= SIZE_64;
                        master_read_beat_count <= split_len_q;
                        state_q <= ABS_ADDR;
                    end
                end
                default: begin
                    if (busy_done) begin
                        state_q <= ABS_IDLE;
                        done_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Write data path
    // ------------------------------------------------------------
    logic f_valid;
    logic [63:0] f_data;
    wire pull = f_valid && beats_q != 8'h00 && (!w_valid_q || w_ready)
        && !(w_fire && beats_q == 8'h01);
    // Word beats of a store-multiple alternate between lane halves.
    wire [7:0] next_strb = wsize_q == SIZE_32 ? ~strb_q : strb_q;

    abs_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(wd_valid),
        .in_ready(wd_ready),
        .in_data(wd_data),
        .out_valid(f_valid),
        .out_ready(pull),
        .out_data(f_data)
    );

    logic [7:0] issued_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_valid_q <= 1'b0;
            w_data_q <= '0;
            w_last_q <= 1'b0;
            master_write_lane_strobes <= 8'h00;
            issued_q <= 8'h00;
        end else begin
            if (w_fire) w_valid_q <= 1'b0;
            if (state_q == ABS_IDLE) issued_q <= 8'h00;
            if (pull) begin
                w_valid_q <= 1'b1;
                w_data_q <= f_data;
                w_last_q <= (beats_q - (w_fire ? 8'h01 : 8'h00))
                    == issued_q + 8'h01 - issued_q;
                master_write_lane_strobes <= issued_q[0]
                    ? next_strb : strb_q;
                issued_q <= issued_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_fault_quiet: assert property (@(posedge clk) disable iff (rst)
        take && misalign |=> !aw_valid_q && !ar_valid_q && fault_q)
        else $error("faulting request reached the bus");
    a_half_odd: assert property (@(posedge clk) disable iff (rst)
        take && is_hs && req_addr[0] |=> fault_q)
        else $error("odd halfword store did not fault");
    a_aw_incr: assert property (@(posedge clk) disable iff (rst)
        aw_valid_q |-> master_write_burst_type == BURST_INCR)
        else $error("write burst not incrementing");
    a_small_one: assert property (@(posedge clk) disable iff (rst)
        ar_valid_q && master_read_beat_size <= SIZE_16
        |-> master_read_beat_count == LEN_1)
        else $error("narrow read burst longer than one beat");
    a_fill_shape: assert property (@(posedge clk) disable iff (rst)
        take && is_fill && req_cache_en |=> ar_valid_q
        && master_read_burst_type == BURST_WRAP
        && master_read_addr[2:0] == 3'h0
        && master_read_addr[4:3] == $past(req_addr[4:3]))
        else $error("linefill shape wrong");
    a_evict_line: assert property (@(posedge clk) disable iff (rst)
        take && is_ev && req_line_dirty |=> aw_valid_q
        && master_write_addr[4:0] == 5'h00
        && master_write_beat_count == LEN_4)
        else $error("write-back not line aligned");
    a_stb_quiet: assert property (@(posedge clk) disable iff (rst)
        take && is_ncl && req_stb_hit |=> !ar_valid_q ##1 !ar_valid_q)
        else $error("buffer hit load issued a read");
    a_no_cross: assert property (@(posedge clk) disable iff (rst)
        ar_valid_q && master_read_beat_size == SIZE_64
        && master_read_burst_type == BURST_INCR
        |-> {1'b0, master_read_addr[4:3]}
        + master_read_beat_count[2:0] <= 3'h3)
        else $error("read burst crosses a line");
endmodule
`default_nettype wire

// *** verif/abs_axi_slave.sv ***
/*
 * Slave model for the far side of the burst shaper's master port.
 * Assumes the testbench picks the ready pattern through the mode input.
 */
`default_nettype none
module abs_axi_slave (
    input wire logic clk, // clock
    input wire logic rst, // async reset, active high
    input wire logic [1:0] mode, // 0 prompt, 1 slow, 2 write data stalled
    input wire logic aw_valid_q, // write address valid
    input wire logic [31:0] master_write_addr, // write address
    input wire logic [1:0] master_write_burst_type, // write burst type
    input wire logic [2:0] master_write_beat_size, // write beat size
    input wire logic [7:0] master_write_beat_count, // write beats minus one
    output logic aw_ready, // write address ready
    input wire logic w_valid_q, // write data valid
    input wire logic [7:0] master_write_lane_strobes, // write strobes
    output logic w_ready, // write data ready
    input wire logic ar_valid_q, // read address valid
    input wire logic [31:0] master_read_addr, // read address
    input wire logic [1:0] master_read_burst_type, // read burst type
    input wire logic [2:0] master_read_beat_size, // read beat size
    input wire logic [7:0] master_read_beat_count, // read beats minus one
    output logic ar_ready // read address ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [63:0] aw_q[$];
    logic [63:0] ar_q[$];
    logic [63:0] w_q[$];
    int n_viol = 0;
    logic tick_q;

    // ----------------------------------------------------------------
    // Shape checks on every accepted burst
    // ----------------------------------------------------------------
    function automatic bit bad(input logic [31:0] a, input logic [1:0] b,
                               input logic [2:0] s, input logic [7:0] l,
                               input bit wr);
        int span;
        span = int'(a[4:0]) + ((int'(l) + 1) << s);
        return (b != 2'h2 && span > 32)
            || (s < 3'h2 && l != 8'h00)
            || (wr && b != 2'h1);
    endfunction

    task automatic clear;
        aw_q.delete();
        ar_q.delete();
        w_q.delete();
    endtask

    // ----------------------------------------------------------------
    // Ready generation and capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_q <= 1'b0;
            aw_ready <= 1'b0;
            w_ready <= 1'b0;
            ar_ready <= 1'b0;
        end else begin
            tick_q <= ~tick_q;
            aw_ready <= (mode == 2'h0) | tick_q;
            w_ready <= (mode == 2'h0) | ((mode == 2'h1) & tick_q);
            ar_ready <= (mode == 2'h0) | tick_q;
        end
    end

    // Any legal size and length is taken as it comes.
    always @(posedge clk) begin
        if (!rst && aw_valid_q && aw_ready) begin
            aw_q.push_back({19'h0, master_write_addr, master_write_burst_type,
                            master_write_beat_size, master_write_beat_count});
            n_viol += int'(bad(master_write_addr, master_write_burst_type,
                master_write_beat_size, master_write_beat_count, 1'b1));
        end
        if (!rst && ar_valid_q && ar_ready) begin
            ar_q.push_back({19'h0, master_read_addr, master_read_burst_type,
                            master_read_beat_size, master_read_beat_count});
            n_viol += int'(bad(master_read_addr, master_read_burst_type,
                master_read_beat_size, master_read_beat_count, 1'b0));
        end
        if (!rst && w_valid_q && w_ready)
            w_q.push_back({56'h0, master_write_lane_strobes});
    end
endmodule
`default_nettype wire

// *** verif/test_axi_master_burst_shaping.sv ***
/*
 * Self-checking testbench for the burst shaper.
 * Assumes abs_pkg, abs_fifo, abs_shaper and the slave model are compiled.
 */
`default_nettype none
module test_axi_master_burst_shaping;
    timeunit 1ns;
    timeprecision 100ps;
    import abs_pkg::*;
    logic clk = 0, rst = 1, req_valid = 0, req_cache_en = 0;
    logic req_line_dirty = 0, req_stb_hit = 0, wd_valid = 0, flt;
    logic [2:0] req_op = 0, req_nc_words = 0;
    logic [31:0] req_addr = 0, master_write_addr, master_read_addr;
    logic [63:0] wd_data = 0, w_data_q;
    logic [1:0] mode = 0, master_write_burst_type, master_read_burst_type;
    logic [2:0] master_write_beat_size, master_read_beat_size;
    logic [7:0] master_write_beat_count, master_read_beat_count;
    logic [7:0] master_write_lane_strobes;
    logic req_ready, fault_q, done_q, wd_ready, aw_valid_q, aw_ready;
    logic w_last_q, w_valid_q, w_ready, ar_valid_q, ar_ready;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;

    abs_shaper #(.FIFO_DEPTH(16)) dut (.clk, .rst, .req_valid, .req_ready,
        .req_op, .req_addr, .req_cache_en, .req_line_dirty, .req_nc_words,
        .req_stb_hit, .fault_q, .done_q, .wd_valid, .wd_ready, .wd_data,
        .master_write_addr, .master_write_burst_type, .master_write_beat_size,
        .master_write_beat_count, .aw_valid_q, .aw_ready, .w_data_q,
        .master_write_lane_strobes, .w_last_q, .w_valid_q, .w_ready,
        .master_read_addr, .master_read_burst_type, .master_read_beat_size,
        .master_read_beat_count, .ar_valid_q, .ar_ready);
    abs_axi_slave slv (.clk, .rst, .mode, .aw_valid_q, .master_write_addr,
        .master_write_burst_type, .master_write_beat_size,
        .master_write_beat_count, .aw_ready, .w_valid_q,
        .master_write_lane_strobes, .w_ready, .ar_valid_q, .master_read_addr,
        .master_read_burst_type, .master_read_beat_size,
        .master_read_beat_count, .ar_ready);

    always #2.5 clk = ~clk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [63:0] bt(input logic [31:0] a,
        input logic [1:0] b, input logic [2:0] s, input logic [7:0] l);
        return {19'h0, a, b, s, l};
    endfunction

    task automatic push(input int n);
        @(posedge clk);
        wd_valid <= 1'b1;
        for (int i = 0; i < n; i++) begin
            wd_data <= 64'h5a00_0000_0000_0000 + 64'(i);
            @(posedge clk);
            while (wd_ready !== 1'b1) @(posedge clk);
        end
        wd_valid <= 1'b0;
    endtask

    // Issues one request, holds it until taken, then waits for retirement.
    task automatic run(input logic [2:0] op, input logic [31:0] a,
        input logic ce = 1'b0, input logic dty = 1'b0,
        input logic [2:0] nw = 3'h0, input logic hit = 1'b0);
        int k;
        slv.clear();
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_cache_en <= ce;
        req_line_dirty <= dty;
        req_nc_words <= nw;
        req_stb_hit <= hit;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 100);
        req_valid <= 1'b0;
        flt = 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (fault_q === 1'b1) flt = 1'b1;
        end while (done_q !== 1'b1 && k < 300);
        if (k >= 300) chk(64'h0, 64'h1);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_half;
        for (int i = 0; i < 4; i++) begin
            push(1);
            run(ABS_HSTORE, 32'h100 + 32'(2 * i));
            chk(64'(slv.aw_q.size()), 64'h1);
            chk(slv.aw_q[0], bt(32'h100 + 32'(2 * i), BURST_INCR, SIZE_16,
                LEN_1));
            chk(slv.w_q[0], 64'(8'h03 << (2 * i)));
        end
    endtask

    task automatic t_fault;
        logic [2:0] ops[8] = '{ABS_HSTORE, ABS_HSTORE, ABS_HSTORE,
            ABS_WSTORE, ABS_WSTORE, ABS_WSTORE, ABS_ST7, ABS_ST7};
        logic [31:0] ads[8] = '{32'h501, 32'h503, 32'h507, 32'h501,
            32'h502, 32'h506, 32'h501, 32'h505};
        for (int i = 0; i < 8; i++) begin
            run(ops[i], ads[i]);
            chk(64'(flt), 64'h1);
            chk(64'(slv.aw_q.size() + slv.w_q.size() + slv.ar_q.size()),
                64'h0);
        end
    endtask

    task automatic t_words;
        for (int i = 0; i < 2; i++) begin
            push(1);
            run(ABS_WSTORE, 32'h200 + 32'(4 * i));
            chk(slv.aw_q[0], bt(32'h200 + 32'(4 * i), BURST_INCR, SIZE_32,
                LEN_1));
            chk(slv.w_q[0], i ? 64'hf0 : 64'h0f);
            push(7);
            run(ABS_ST7, 32'h300 + 32'(4 * i));
            chk(slv.aw_q[0], bt(32'h300 + 32'(4 * i), BURST_INCR, SIZE_32,
                LEN_7));
            chk(64'(slv.w_q.size()), 64'(ST7_BEATS));
            chk(slv.w_q[0], i ? 64'hf0 : 64'h0f);
            chk(w_data_q, 64'h5a00_0000_0000_0006);
            chk(64'(w_last_q), 64'h1);
        end
    endtask

    task automatic t_fill;
        logic [31:0] a;
        for (int i = 0; i < 4; i++) begin
            a = 32'h1003 + 32'(9 * i);
            run(ABS_FILL, a, 1'b1);
            chk(64'(slv.ar_q.size()), 64'h1);
            chk(slv.ar_q[0], bt({a[31:3], 3'h0}, BURST_WRAP, SIZE_64,
                LEN_4));
        end
    endtask

    task automatic t_evict;
        push(4);
        run(ABS_EVICT, 32'h2014, 1'b0, 1'b1);
        chk(slv.aw_q[0], bt(32'h2000, BURST_INCR, SIZE_64, LEN_4));
        chk(64'(slv.w_q.size()), 64'(WB_BEATS));
        run(ABS_EVICT, 32'h2034);
        chk(64'(slv.aw_q.size()), 64'h0);
    endtask

    task automatic t_nc;
        run(ABS_NCLOAD, 32'h3004);
        chk(slv.ar_q[0], bt(32'h3004, BURST_INCR, SIZE_16, LEN_1));
        run(ABS_NCLOAD, 32'h3010, 1'b0, 1'b0, 3'h5);
        chk(64'(slv.ar_q.size()), 64'h2);
        chk(slv.ar_q[0], bt(32'h3010, BURST_INCR, SIZE_64, 8'h01));
        chk(slv.ar_q[1], bt(32'h3020, BURST_INCR, SIZE_64, LEN_1));
        run(ABS_NCLOAD, 32'h3008, 1'b0, 1'b0, 3'h5);
        chk(slv.ar_q[0], bt(32'h3008, BURST_INCR, SIZE_64, 8'h02));
        run(ABS_NCLOAD, 32'h3004, 1'b0, 1'b0, 3'h1);
        chk(slv.ar_q[0], bt(32'h3000, BURST_INCR, SIZE_64, LEN_1));
        run(ABS_NCLOAD, 32'h3010, 1'b0, 1'b0, 3'h5, 1'b1);
        chk(64'(slv.ar_q.size()), 64'h0);
    endtask

    // Fills the write buffer against a stalled slave, then drains it slowly.
    task automatic t_buffer;
        int n;
        @(posedge clk);
        mode <= 2'h2;
        wd_valid <= 1'b1;
        n = 0;
        repeat (24) begin
            wd_data <= 64'(n);
            @(posedge clk);
            if (wd_ready !== 1'b1) break;
            n++;
        end
        wd_valid <= 1'b0;
        mode <= 2'h1;
        chk(64'(n), 64'd16);
        run(ABS_ST7, 32'h400);
        chk(64'(slv.w_q.size()), 64'h7);
        run(ABS_EVICT, 32'h420, 1'b0, 1'b1);
        chk(64'(slv.w_q.size()), 64'h4);
        run(ABS_EVICT, 32'h440, 1'b0, 1'b1);
        chk(64'(slv.w_q.size()), 64'h4);
        run(ABS_HSTORE, 32'h460);
        chk(slv.w_q[0], 64'h03);
        chk(64'(wd_ready), 64'h1);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        chk({59'h0, aw_valid_q, w_valid_q, ar_valid_q, fault_q, done_q},
            64'h0);
        chk(64'(master_write_burst_type), 64'(BURST_INCR));
        t_half();
        t_fault();
        t_words();
        t_fill();
        t_evict();
        t_nc();
        t_buffer();
        chk(64'(slv.n_viol), 64'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
